// >>> logic/dmabm_device.sv
`timescale 1ns/100ps
// Overview of operation
// - config bit 0 picks mask or byte pins
// - lane mask driven only as bus master
// - mask codes select whole word or byte
// - byte line plus address bit0 pick bytes
// - byte qualifier driven except in reset, low only as master
// - level request ignores previous pin state
// - level request held low whole transaction
// - config bit 1 sets strobe polarity
// - strobe asserted in address phase, master only
// - low grant after request makes master
// - arbiter withdraws grant only after release
// - slave may latch address on strobe rise
// - config bit 6 makes pin 15 release input
module dmabm_device
	import dmabm_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [dmabm_pkg::CFG_WIDTH-1:0] bus_config_reg,
	input wire logic dma_need,
	input wire logic [1:0] xfer_lanes,
	input wire logic [dmabm_pkg::ADDR_WIDTH-1:0] xfer_addr,
	output logic xfer_done,
	output logic bus_master,
	output logic burst_released,
	dmabm_link_if.device link
);
	import dmabm_pkg::*;

	typedef enum logic [2:0] {IDLE, REQ, ADDR, DATA, REL} dmabm_state_e;
	dmabm_state_e state;
	logic [3:0] cnt;
	logic req_pin_prev;
	logic byte_mode;
	logic strobe_act_low;
	logic rel_mode;
	logic master;

	assign byte_mode = bus_config_reg[CFG_BUS_STYLE_BIT];
	assign strobe_act_low = bus_config_reg[CFG_STROBE_POL_BIT];
	assign rel_mode = bus_config_reg[CFG_BURST_REL_BIT];
	// the REQ state is not mastership; the grant must be seen first
	assign master = (state == ADDR) || (state == DATA);

	// ---------------------------------------------------------------
	// request sequencing
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		// pull-up level, so edge style may request right after reset
		if (srst)
			req_pin_prev <= 1'b1;
		else
			req_pin_prev <= link.request_i;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			state <= IDLE;
			cnt <= 4'h0;
			burst_released <= 1'b0;
		end
		else
		begin
			case (state)
				IDLE:
				begin
					burst_released <= 1'b0;
					// edge style waits for the pin to be seen high first
					if (dma_need && link.master_grant_in && (!byte_mode || req_pin_prev))
						state <= REQ;
				end
				REQ:
				begin
					if (!link.master_grant_in)
					begin
						state <= ADDR;
						cnt <= ADDR_CYCLES;
					end
				end
				ADDR:
				begin
					if (cnt == 4'h1)
					begin
						state <= DATA;
						cnt <= DATA_CYCLES;
					end
					else
						cnt <= cnt - 4'h1;
				end
				DATA:
				begin
					// burst length is set by dma_need and, with config bit 6, the release input; no count caps it
					if (cnt == 4'h1)
					begin
						// release input ends the burst after the current transfer
						if (rel_mode && link.pin15_i)
						begin
							burst_released <= 1'b1;
							state <= REL;
						end
						else if (dma_need)
						begin
							state <= ADDR;
							cnt <= ADDR_CYCLES;
						end
						else
							state <= REL;
					end
					else
						cnt <= cnt - 4'h1;
				end
				REL:
				begin
					// wait for grant to go away before a new request
					if (link.master_grant_in)
						state <= IDLE;
				end
				default:
					state <= IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// pin drivers
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			link.request_o <= 1'b1;
			link.request_oe_n <= 1'b1;
		end
		else
		begin
			link.request_o <= 1'b0;
			link.request_oe_n <= !(state == REQ || state == ADDR || state == DATA);
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			link.strobe_o <= 1'b0;
			link.strobe_oe_n <= 1'b1;
			link.addr_bit0_o <= 1'b0;
			link.addr_bit0_oe_n <= 1'b1;
		end
		else
		begin
			// inverted polarity lets a slave latch on the rising edge
			link.strobe_o <= (state == ADDR) ^ strobe_act_low;
			link.strobe_oe_n <= !master;
			link.addr_bit0_o <= (state == ADDR) ? xfer_addr[0] : link.addr_bit0_o;
			link.addr_bit0_oe_n <= !(state == ADDR);
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			link.pin15_o <= 1'b0;
			link.pin15_oe_n <= 1'b1;
			link.pin16_o <= 1'b1;
			link.pin16_oe_n <= 1'b1;
		end
		else if (byte_mode)
		begin
			// byte line high selects a byte; address bit0 picks which
			// pin 16 is driven low as master and high otherwise, and is floated in this style only during reset
			link.pin15_o <= (xfer_lanes != MASK_WORD);
			link.pin15_oe_n <= !master || rel_mode;
			link.pin16_o <= !master;
			link.pin16_oe_n <= 1'b0;
		end
		else
		begin
			link.pin15_o <= xfer_lanes[0];
			link.pin15_oe_n <= !master || rel_mode;
			link.pin16_o <= xfer_lanes[1];
			link.pin16_oe_n <= !master;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			xfer_done <= 1'b0;
			bus_master <= 1'b0;
		end
		else
		begin
			xfer_done <= (state == DATA) && (cnt == 4'h1);
			bus_master <= master;
		end
	end
endmodule : dmabm_device

// >>> logic/dmabm_pkg.sv
package dmabm_pkg;
	// configuration bit positions
	localparam int unsigned CFG_BUS_STYLE_BIT = 0;
	localparam int unsigned CFG_STROBE_POL_BIT = 1;
	localparam int unsigned CFG_BURST_REL_BIT = 6;
	localparam int unsigned CFG_WIDTH = 8;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// lane mask codes {hi, lo}
	localparam logic [1:0] MASK_WORD = 2'h0;
	localparam logic [1:0] MASK_UPPER = 2'h1;
	localparam logic [1:0] MASK_LOWER = 2'h2;
	// cycles of address phase and data phase
	localparam logic [3:0] ADDR_CYCLES = 4'h1;
	localparam logic [3:0] DATA_CYCLES = 4'h2;
	localparam int unsigned ADDR_WIDTH = 16;
endpackage : dmabm_pkg

// >>> logic/dmabm_link_if.sv
`timescale 1ns/100ps
interface dmabm_link_if;
	logic pin15_o;
	logic pin15_oe_n;
	logic pin15_i;
	logic pin16_o;
	logic pin16_oe_n;
	logic request_o;
	logic request_oe_n;
	logic request_i;
	logic strobe_o;
	logic strobe_oe_n;
	logic addr_bit0_o;
	logic addr_bit0_oe_n;
	logic master_grant_in;
	logic burst_release_drv;
	// wires resolved here: open-drain request with pull-up, three-state pin 15
	assign request_i = request_oe_n ? 1'b1 : request_o;
	assign pin15_i = pin15_oe_n ? burst_release_drv : pin15_o;
	modport device (
		output pin15_o, pin15_oe_n, pin16_o, pin16_oe_n, request_o, request_oe_n,
		output strobe_o, strobe_oe_n, addr_bit0_o, addr_bit0_oe_n,
		input pin15_i, request_i, master_grant_in
	);
	modport arbiter (
		input pin15_o, pin15_oe_n, pin16_o, pin16_oe_n, request_i,
		input strobe_o, strobe_oe_n, addr_bit0_o, addr_bit0_oe_n,
		output master_grant_in, burst_release_drv
	);
endinterface : dmabm_link_if

// >>> logic/dmabm_arbiter.sv
`timescale 1ns/100ps
module dmabm_arbiter
	import dmabm_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic grant_allow,
	input wire logic release_req,
	input wire logic bus_style,
	output logic grant_active,
	output logic addr_valid,
	output logic [1:0] lane_sel,
	output logic illegal_sel,
	dmabm_link_if.arbiter link
);
	import dmabm_pkg::*;

	logic strobe_prev;
	logic bit0_oe_prev;
	logic addr_bit0_lat;
	logic addr_end;

	// the address phase ends when address bit 0 is released; this holds for
	// either strobe polarity, so the lanes are captured in both styles
	assign addr_end = link.addr_bit0_oe_n && !bit0_oe_prev;

	// grant pulled low on request low when grant_allow is set; withdrawn only after release
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			link.master_grant_in <= 1'b1;
			grant_active <= 1'b0;
		end
		else
		begin
			if (!link.request_i && grant_allow)
				link.master_grant_in <= 1'b0;
			else if (link.request_i)
				link.master_grant_in <= 1'b1;
			grant_active <= !link.master_grant_in;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			link.burst_release_drv <= 1'b0;
		else
			link.burst_release_drv <= release_req;
	end

	// ---------------------------------------------------------------
	// address capture on strobe rise and address bit 0 release
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			strobe_prev <= 1'b1;
			bit0_oe_prev <= 1'b1;
			addr_bit0_lat <= 1'b0;
			addr_valid <= 1'b0;
			lane_sel <= MASK_WORD;
			illegal_sel <= 1'b0;
		end
		else
		begin
			strobe_prev <= link.strobe_oe_n ? 1'b1 : link.strobe_o;
			bit0_oe_prev <= link.addr_bit0_oe_n;
			// a floated address bit shows a stale value, so only the driven one is kept
			if (!link.addr_bit0_oe_n)
				addr_bit0_lat <= link.addr_bit0_o;
			addr_valid <= !link.strobe_oe_n && !strobe_prev && link.strobe_o;
			if (addr_end)
			begin
				// byte-select low with address bit0 high is illegal in byte style only
				illegal_sel <= bus_style && !link.pin15_o && addr_bit0_lat;
				lane_sel <= {link.pin16_o, link.pin15_o};
			end
		end
	end
endmodule : dmabm_arbiter

// >>> dv/dmabm_monitor.sv
`timescale 1ns/100ps
module dmabm_monitor (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic request_o,
	input wire logic request_oe_n,
	input wire logic request_i,
	input wire logic strobe_o,
	input wire logic strobe_oe_n,
	input wire logic pin15_oe_n,
	input wire logic master_grant_in
);
	// --------
	// link wire rules
	// --------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);
	req_low_a: assert property (!request_oe_n |-> !request_o)
		else $error("request driven high");
	req_hold_a: assert property ($fell(request_oe_n) |-> !request_oe_n [*5])
		else $error("request dropped early");
	grant_answer_a: assert property ($fell(master_grant_in) |-> !request_i)
		else $error("grant without request");
	grant_keep_a: assert property ($rose(master_grant_in) |-> request_oe_n)
		else $error("grant withdrawn under request");
	strobe_master_a: assert property (!strobe_oe_n |-> !master_grant_in)
		else $error("strobe driven as slave");
	pin15_master_a: assert property (!pin15_oe_n |-> !master_grant_in)
		else $error("pin15 driven as slave");
	// address phase is one cycle, so the level must turn on the next edge
	strobe_pulse_a: assert property ($fell(strobe_oe_n) |=>
		strobe_o != $past(strobe_o) ##1 $stable(strobe_o))
		else $error("strobe phase length wrong");
	float_first_a: assert property ($rose(master_grant_in) |->
		strobe_oe_n && pin15_oe_n)
		else $error("outputs driven at grant drop");
endmodule : dmabm_monitor

// >>> dv/tb_dma_bus_mastership_handshake.sv
`timescale 1ns/100ps
module tb_dma_bus_mastership_handshake;
	import dmabm_pkg::*;
	logic core_clk = 0;
	logic srst = 1;
	logic [7:0] cfg = 8'h00;
	logic need = 0;
	logic [1:0] lanes = 2'h0;
	logic [15:0] addr = 16'h0000;
	logic allow = 1;
	logic rel = 0;
	logic done, master, released, g_act, a_val, ill, seen;
	logic [1:0] lsel;
	int fail_count = 0;
	int n_checks = 0;
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) if (a_val) seen <= 1'b1;
	dmabm_link_if link ();
	dmabm_device dmabm_device_inst (.core_clk(core_clk), .srst(srst), .bus_config_reg(cfg),
		.dma_need(need), .xfer_lanes(lanes), .xfer_addr(addr), .xfer_done(done),
		.bus_master(master), .burst_released(released), .link(link));
	dmabm_arbiter dmabm_arbiter_inst (.core_clk(core_clk), .srst(srst), .grant_allow(allow),
		.release_req(rel), .bus_style(cfg[CFG_BUS_STYLE_BIT]),
		.grant_active(g_act), .addr_valid(a_val), .lane_sel(lsel),
		.illegal_sel(ill), .link(link));
	dmabm_monitor dmabm_monitor_inst (.core_clk(core_clk), .srst(srst),
		.request_o(link.request_o), .request_oe_n(link.request_oe_n),
		.request_i(link.request_i), .strobe_o(link.strobe_o), .strobe_oe_n(link.strobe_oe_n),
		.pin15_oe_n(link.pin15_oe_n), .master_grant_in(link.master_grant_in));
	// --------
	// helpers
	// --------
	task automatic chk(input logic [1:0] got, input logic [1:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t got %b exp %b", $time, got, exp);
		end
	endtask : chk
	// bounded so a stuck handshake shows as a mismatch, not a hang
	task automatic wait_for(ref logic sig, input logic lvl);
		for (int i = 0; i < 40 && sig !== lvl; i++) @(negedge core_clk);
		if (sig !== lvl)
		begin
			fail_count++;
			$display("[FAIL] %0t handshake timed out", $time);
		end
	endtask : wait_for
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	// --------
	// scenarios
	// --------
	task automatic xfer(input logic [7:0] c, input logic [1:0] l, input logic a0);
		cfg = c;
		lanes = l;
		addr = {15'h0000, a0};
		seen = 1'b0;
		need = 1;
		wait_for(master, 1);
		// drop the need early so only one transfer runs
		need = 0;
		wait_for(done, 1);
		chk({1'b0, done}, 2'h1);
		chk(lsel, c[0] ? {1'b0, l != 2'h0} : l);
		chk({1'b0, ill}, {1'b0, c[0] && l == 2'h0 && a0});
		wait_for(g_act, 0);
		// the capture pulse lands in seen one edge after it, so look late
		chk({1'b0, seen}, {1'b0, c[1]});
		@(negedge core_clk);
	endtask : xfer
	task automatic refused();
		allow = 0;
		need = 1;
		repeat (10) @(negedge core_clk);
		chk({master, link.request_i}, 2'h0);
		allow = 1;
		wait_for(master, 1);
		chk({1'b0, master}, 2'h1);
		need = 0;
		wait_for(g_act, 0);
		@(negedge core_clk);
	endtask : refused
	task automatic burst_end();
		cfg = 8'h40;
		rel = 1;
		need = 1;
		wait_for(released, 1);
		chk({1'b0, released}, 2'h1);
		need = 0;
		rel = 0;
		wait_for(g_act, 0);
		chk({1'b0, master}, 2'h0);
	endtask : burst_end
	initial
	begin
		repeat (4) @(negedge core_clk);
		srst = 0;
		for (int k = 0; k < 12; k++) xfer({6'h00, k[1:0]}, k[3:2], k[1]);
		refused();
		burst_end();
		summarize();
	end
	initial
	begin
		#200000;
		fail_count++;
		summarize();
	end
endmodule : tb_dma_bus_mastership_handshake
